// ===== inc/memory_space_pkg.sv
// Constants and types for the memory space decoder.
// Assumes a single 25 MHz clock domain shared with the core.
package memory_space_pkg;

    // ----------------------------------------------------------------
    // Program memory map
    // ----------------------------------------------------------------
    localparam logic [15:0] PROG_TOP_64K = 16'hFFFF;
    localparam logic [15:0] PROG_TOP_32K = 16'h7FFF;
    localparam logic [15:0] LOCK_ADDR_64K = 16'hFBFF;
    localparam logic [15:0] LOCK_ADDR_32K = 16'h7FFF;
    localparam logic [15:0] RESV_ABOVE_64K = 16'hFDFF;

    // ----------------------------------------------------------------
    // Internal data map
    // ----------------------------------------------------------------
    localparam logic [7:0] LOWER_TOP = 8'h7F;
    localparam logic [7:0] BANK_TOP = 8'h1F;
    localparam logic [7:0] BITAREA_BASE = 8'h20;
    localparam logic [7:0] BITAREA_TOP = 8'h2F;
    localparam logic [7:0] SP_RESET = 8'h07;
    localparam int unsigned IRAM_BYTES = 256;
    localparam int unsigned AUXILIARY_ONCHIP_RAM_BYTES = 4096;
    localparam int unsigned BANK_SEL_LSB = 3;

    // ----------------------------------------------------------------
    // Access kinds
    // ----------------------------------------------------------------
    typedef enum logic [2:0] {
        ACC_NONE = 3'b000,
        ACC_CODE = 3'b001,
        ACC_EXT = 3'b010,
        ACC_DIRECT = 3'b011,
        ACC_INDIRECT = 3'b100,
        ACC_PUSH = 3'b101,
        ACC_POP = 3'b110
    } access_e;

    typedef enum logic [2:0] {
        TGT_NONE = 3'b000,
        TGT_FLASH = 3'b001,
        TGT_AUXILIARY_ONCHIP_RAM = 3'b010,
        TGT_IRAM = 3'b011,
        TGT_PERIPH = 3'b100,
        TGT_FLASH_WR = 3'b101
    } target_e;

endpackage : memory_space_pkg

// ===== core/memory_space_decoder.sv
// Memory space decoder: program, internal data, auxiliary RAM, stack.
// Assumes the core presents one access per cycle, synchronous to clk_i.
`timescale 1ns/100ps
`default_nettype none

module memory_space_decoder
    import memory_space_pkg::*;
#(
    parameter bit LARGE_PART = 1'b1
)(
    input wire logic clk_i,
    input wire logic resetn_i,
    input wire logic req_i,
    input wire logic [2:0] kind_i,
    input wire logic write_i,
    input wire logic bit_op_i,
    input wire logic [15:0] addr_i,
    input wire logic ptr_sel_i,
    input wire logic [7:0] wdata_i,
    input wire logic flash_write_en_i,
    input wire logic [7:0] program_status_word_i,
    input wire logic [7:0] flash_rdata_i,
    input wire logic [7:0] periph_rdata_i,
    output logic flash_re_o,
    output logic flash_we_o,
    output logic [15:0] flash_addr_o,
    output logic periph_re_o,
    output logic periph_we_o,
    output logic [7:0] periph_addr_o,
    output logic is_lock_byte_o,
    output logic is_reserved_o,
    output logic out_of_range_o,
    output logic [7:0] stack_pointer_reg_o,
    output logic [7:0] rdata_o,
    output logic rvalid_o,
    output logic [2:0] target_o
);

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [7:0] sp;
        logic [7:0] rdata;
        logic rvalid;
        logic [2:0] target;
        logic [IRAM_BYTES-1:0][7:0] iram;
        logic [AUXILIARY_ONCHIP_RAM_BYTES-1:0][7:0] auxiliary_onchip_ram;
    } state_s;

    state_s st_q;
    state_s st_d;

    access_e kind;
    logic [1:0] bank_select_field;
    logic [7:0] iaddr;
    logic [7:0] ptr;
    logic [6:0] bitno;
    logic [7:0] byte_sel;
    logic [11:0] xaddr;

    // Bit address to byte holding it
    function automatic logic [7:0] bit_byte(input logic [6:0] b);
        bit_byte = BITAREA_BASE + {4'h0, b[6:3]};
    endfunction : bit_byte

    // Register index within the active bank
    function automatic logic [7:0] bank_reg(input logic [1:0] bank, input logic [2:0] r);
        bank_reg = {3'b000, bank, r};
    endfunction : bank_reg

    assign kind = access_e'(kind_i);
    assign bank_select_field = program_status_word_i[BANK_SEL_LSB +: 2];
    assign iaddr = addr_i[7:0];
    assign xaddr = addr_i[11:0];
    assign bitno = addr_i[6:0];
    assign byte_sel = bit_byte(bitno);

    // ----------------------------------------------------------------
    // Program memory and peripheral strobe decode
    // ----------------------------------------------------------------
    always_comb
    begin
        is_lock_byte_o = LARGE_PART ? (addr_i == LOCK_ADDR_64K) : (addr_i == LOCK_ADDR_32K);
        is_reserved_o = LARGE_PART && (addr_i > RESV_ABOVE_64K);
        out_of_range_o = LARGE_PART ? (addr_i > PROG_TOP_64K) : (addr_i > PROG_TOP_32K);
        flash_addr_o = addr_i;
        flash_re_o = req_i && (kind == ACC_CODE);
        flash_we_o = req_i && (kind == ACC_EXT) && write_i && flash_write_en_i;
        periph_addr_o = iaddr;
        periph_re_o = req_i && (kind == ACC_DIRECT) && !write_i && (iaddr > LOWER_TOP) && !bit_op_i;
        periph_we_o = req_i && (kind == ACC_DIRECT) && write_i && (iaddr > LOWER_TOP) && !bit_op_i;
    end

    // ----------------------------------------------------------------
    // Access engine
    // ----------------------------------------------------------------
    always_comb
    begin
        st_d = st_q;
        st_d.rvalid = 1'b0;
        st_d.target = TGT_NONE;
        ptr = st_q.iram[bank_reg(bank_select_field, {2'b00, ptr_sel_i})];
        if (req_i)
        begin
            case (kind)
                ACC_CODE:
                begin
                    st_d.target = TGT_FLASH;
                    st_d.rdata = flash_rdata_i;
                    st_d.rvalid = 1'b1;
                end
                ACC_EXT:
                begin
                    if (write_i && flash_write_en_i)
                    begin
                        st_d.target = TGT_FLASH_WR;
                    end
                    else if (write_i)
                    begin
                        st_d.target = TGT_AUXILIARY_ONCHIP_RAM;
                        st_d.auxiliary_onchip_ram[xaddr] = wdata_i;
                    end
                    else
                    begin
                        st_d.target = TGT_AUXILIARY_ONCHIP_RAM;
                        st_d.rdata = st_q.auxiliary_onchip_ram[xaddr];
                        st_d.rvalid = 1'b1;
                    end
                end
                ACC_DIRECT:
                begin
                    if (bit_op_i && !iaddr[7] && (byte_sel <= BITAREA_TOP))
                    begin
                        st_d.target = TGT_IRAM;
                        if (write_i)
                        begin
                            st_d.iram[byte_sel][bitno[2:0]] = wdata_i[0];
                        end
                        else
                        begin
                            st_d.rdata = {7'h00, st_q.iram[byte_sel][bitno[2:0]]};
                            st_d.rvalid = 1'b1;
                        end
                    end
                    else if (iaddr > LOWER_TOP)
                    begin
                        st_d.target = TGT_PERIPH;
                        if (!write_i)
                        begin
                            st_d.rdata = periph_rdata_i;
                            st_d.rvalid = 1'b1;
                        end
                    end
                    else
                    begin
                        st_d.target = TGT_IRAM;
                        if (write_i)
                        begin
                            st_d.iram[iaddr] = wdata_i;
                        end
                        else
                        begin
                            st_d.rdata = st_q.iram[iaddr];
                            st_d.rvalid = 1'b1;
                        end
                    end
                end
                ACC_INDIRECT:
                begin
                    st_d.target = TGT_IRAM;
                    if (write_i)
                    begin
                        st_d.iram[ptr] = wdata_i;
                    end
                    else
                    begin
                        st_d.rdata = st_q.iram[ptr];
                        st_d.rvalid = 1'b1;
                    end
                end
                ACC_PUSH:
                begin
                    st_d.target = TGT_IRAM;
                    st_d.iram[8'(st_q.sp + 8'h01)] = wdata_i;
                    st_d.sp = 8'(st_q.sp + 8'h01);
                end
                ACC_POP:
                begin
                    st_d.target = TGT_IRAM;
                    st_d.rdata = st_q.iram[st_q.sp];
                    st_d.rvalid = 1'b1;
                    st_d.sp = 8'(st_q.sp - 8'h01);
                end
                default:
                begin
                    st_d.target = TGT_NONE;
                end
            endcase
        end
    end

    always_ff @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            st_q.sp <= SP_RESET;
            st_q.rdata <= 8'h00;
            st_q.rvalid <= 1'b0;
            st_q.target <= TGT_NONE;
        end
        else
        begin
            st_q <= st_d;
        end
    end

    assign stack_pointer_reg_o = st_q.sp;
    assign rdata_o = st_q.rdata;
    assign rvalid_o = st_q.rvalid;
    assign target_o = st_q.target;

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    sequence push_seq;
        req_i && kind == ACC_PUSH;
    endsequence

    sequence pop_seq;
        req_i && kind == ACC_POP;
    endsequence

    sequence bit_rd_seq;
        req_i && kind == ACC_DIRECT && bit_op_i && !write_i && !iaddr[7];
    endsequence

    sequence ind_rd_seq;
        req_i && kind == ACC_INDIRECT && !write_i;
    endsequence

    sp_push_inc_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
        push_seq |=> stack_pointer_reg_o == 8'($past(stack_pointer_reg_o) + 8'h01))
        else $error("push did not increment pointer");

    sp_pop_dec_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
        pop_seq |=> stack_pointer_reg_o == 8'($past(stack_pointer_reg_o) - 8'h01) && rvalid_o)
        else $error("pop did not decrement pointer");

    code_flash_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
        req_i && kind == ACC_CODE |=> target_o == TGT_FLASH && rdata_o == $past(flash_rdata_i))
        else $error("code read not from flash");

    ext_route_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
        req_i && kind == ACC_EXT && !flash_write_en_i |-> !flash_we_o ##1 target_o == TGT_AUXILIARY_ONCHIP_RAM)
        else $error("external move left auxiliary RAM");

    direct_periph_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
        req_i && kind == ACC_DIRECT && !bit_op_i && iaddr[7] |=> target_o == TGT_PERIPH)
        else $error("direct upper access missed peripheral space");

    indirect_iram_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
        req_i && kind == ACC_INDIRECT |-> !periph_re_o && !periph_we_o ##1 target_o == TGT_IRAM)
        else $error("indirect access reached peripheral space");

    lock_byte_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
        is_lock_byte_o |-> addr_i == (LARGE_PART ? LOCK_ADDR_64K : LOCK_ADDR_32K))
        else $error("lock byte flag wrong");

    reserved_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
        is_reserved_o |-> LARGE_PART && addr_i > RESV_ABOVE_64K && !is_lock_byte_o)
        else $error("reserved flag wrong");

    sp_reset_a: assert property (@(posedge clk_i)
        $rose(resetn_i) |-> stack_pointer_reg_o == SP_RESET)
        else $error("pointer not at reset value");

    push_write_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
        push_seq |=> st_q.iram[stack_pointer_reg_o] == $past(wdata_i))
        else $error("push data not at new top");

    bit_read_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
        bit_rd_seq |=> rvalid_o && target_o == TGT_IRAM && rdata_o[7:1] == 7'h00)
        else $error("bit read returned a byte");

    indirect_read_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
        ind_rd_seq |=> rvalid_o && rdata_o == st_q.iram[$past(ptr)])
        else $error("indirect read missed pointer");

endmodule : memory_space_decoder

`default_nettype wire

// ===== bench/flash_periph_model.sv
// Partner model: flash array and peripheral register read data.
// Assumes strobes and addresses come straight from the decoder, one clock.
`timescale 1ns/100ps
`default_nettype none

module flash_periph_model (
    input wire logic clk_i,
    input wire logic flash_re_i,
    input wire logic [15:0] flash_addr_i,
    input wire logic periph_re_i,
    input wire logic [7:0] periph_addr_i,
    output logic [7:0] flash_rdata_o,
    output logic [7:0] periph_rdata_o
);
    logic [7:0] flash_last = 8'h00;
    logic [7:0] periph_last = 8'h00;

    // --------------------------------------------------------------
    // Data while read, inverse of the last value while released
    // --------------------------------------------------------------
    assign flash_rdata_o = flash_re_i ? (flash_addr_i[15:8] ^ flash_addr_i[7:0] ^ 8'h5A)
                                      : ~flash_last;
    assign periph_rdata_o = periph_re_i ? ~periph_addr_i : ~periph_last;

    always_ff @(posedge clk_i)
    begin
        if (flash_re_i) flash_last <= flash_rdata_o;
        if (periph_re_i) periph_last <= periph_rdata_o;
    end
endmodule : flash_periph_model

`default_nettype wire

// ===== bench/memory_space_decoder_tb.sv
// Self-checking testbench for the memory space decoder, large part.
// Assumes the partner model answers flash and peripheral reads.
`timescale 1ns/100ps
`default_nettype none

module memory_space_decoder_tb;
    import memory_space_pkg::*;
    logic clk_i = 1'b0;
    logic resetn_i = 1'b0;
    logic req = 1'b0, wr = 1'b0, bop = 1'b0, ptr = 1'b0, fwe = 1'b0;
    logic [2:0] kind = 3'h0;
    logic [15:0] addr = 16'h0000;
    logic [7:0] wd = 8'h00, program_status_word = 8'h00;
    logic [7:0] frd, prd, pad, sp, rd;
    logic [15:0] fad;
    logic fre, fwr, pre, pwr, lock, resv, oor, rv;
    logic [2:0] tgt;
    int n_mismatch = 0;
    int n_compared = 0;

    memory_space_decoder #(.LARGE_PART(1'b1)) dut (.clk_i(clk_i), .resetn_i(resetn_i),
        .req_i(req), .kind_i(kind), .write_i(wr), .bit_op_i(bop), .addr_i(addr),
        .ptr_sel_i(ptr), .wdata_i(wd), .flash_write_en_i(fwe), .program_status_word_i(program_status_word),
        .flash_rdata_i(frd), .periph_rdata_i(prd), .flash_re_o(fre), .flash_we_o(fwr),
        .flash_addr_o(fad), .periph_re_o(pre), .periph_we_o(pwr), .periph_addr_o(pad),
        .is_lock_byte_o(lock), .is_reserved_o(resv), .out_of_range_o(oor),
        .stack_pointer_reg_o(sp), .rdata_o(rd), .rvalid_o(rv), .target_o(tgt));

    flash_periph_model partner (.clk_i(clk_i), .flash_re_i(fre), .flash_addr_i(fad),
        .periph_re_i(pre), .periph_addr_i(pad), .flash_rdata_o(frd), .periph_rdata_o(prd));

    initial
    begin
        forever #20 clk_i = ~clk_i;
    end

    // --------------------------------------------------------------
    // Shared tasks
    // --------------------------------------------------------------
    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        n_compared++;
        if (g !== e)
        begin
            n_mismatch++;
            $display("unexpected %s: expected %h seen %h", nm, e, g);
        end
    endtask : chk

    task automatic acc(input logic [2:0] k, input logic w, input logic b,
                       input logic [15:0] a, input logic p, input logic [7:0] d);
        req = 1'b1; kind = k; wr = w; bop = b; addr = a; ptr = p; wd = d;
        #5;
    endtask : acc

    task automatic nxt();
        @(negedge clk_i);
    endtask : nxt

    task automatic idle();
        req = 1'b0; kind = ACC_NONE; wr = 1'b0;
        @(negedge clk_i);
    endtask : idle

    task automatic wr8(input logic [15:0] a, input logic [7:0] d);
        acc(ACC_DIRECT, 1'b1, 1'b0, a, 1'b0, d);
        nxt();
    endtask : wr8

    task automatic print_verdict();
        $display("compared %0d mismatches %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : print_verdict

    // --------------------------------------------------------------
    // Scenarios
    // --------------------------------------------------------------
    task automatic t_stack();
        chk("sp", 16'h07, sp);
        chk("target", 16'h0, tgt);
        acc(ACC_PUSH, 1'b0, 1'b0, 16'h0000, 1'b0, 8'hAA); nxt();
        chk("sp", 16'h08, sp);
        acc(ACC_PUSH, 1'b0, 1'b0, 16'h0000, 1'b0, 8'h55); nxt();
        chk("sp", 16'h09, sp);
        acc(ACC_DIRECT, 1'b0, 1'b0, 16'h0008, 1'b0, 8'h00); nxt();
        chk("rdata", 16'hAA, rd);
        acc(ACC_POP, 1'b0, 1'b0, 16'h0000, 1'b0, 8'h00); nxt();
        chk("rdata", 16'h55, rd);
        chk("rvalid", 16'h1, rv);
        chk("sp", 16'h08, sp);
        idle();
        chk("rvalid", 16'h0, rv);
        resetn_i = 1'b0;
        @(negedge clk_i);
        resetn_i = 1'b1;
        chk("sp", 16'h07, sp);
        $display("test stack done");
    endtask : t_stack

    task automatic t_banks();
        for (int b = 0; b < 4; b++)
        begin
            program_status_word = 8'(b << BANK_SEL_LSB);
            wr8(16'(b * 8), 8'(8'h40 + b));
            wr8(16'(b * 8 + 1), 8'(8'h90 + b));
            wr8(16'(8'h40 + b), 8'(8'hC0 + b));
            acc(ACC_INDIRECT, 1'b1, 1'b0, 16'h0000, 1'b1, 8'(8'hE0 + b));
            chk("periph_we", 16'h0, pwr);
            nxt();
            acc(ACC_INDIRECT, 1'b0, 1'b0, 16'h0000, 1'b0, 8'h00); nxt();
            chk("rdata", 16'(8'hC0 + b), rd);
            chk("target", TGT_IRAM, tgt);
            acc(ACC_INDIRECT, 1'b0, 1'b0, 16'h0000, 1'b1, 8'h00); nxt();
            chk("rdata", 16'(8'hE0 + b), rd);
            acc(ACC_DIRECT, 1'b0, 1'b0, 16'(8'h90 + b), 1'b0, 8'h00);
            chk("periph_addr", 16'(8'h90 + b), pad);
            chk("periph_re", 16'h1, pre);
            nxt();
            chk("target", TGT_PERIPH, tgt);
            chk("rdata", 16'(8'(~(8'h90 + b))), rd);
        end
        idle();
        $display("test banks done");
    endtask : t_banks

    task automatic t_bits();
        wr8(16'h0022, 8'h00);
        wr8(16'h002F, 8'h80);
        acc(ACC_DIRECT, 1'b1, 1'b1, 16'h0013, 1'b0, 8'h01); nxt();
        acc(ACC_DIRECT, 1'b0, 1'b0, 16'h0022, 1'b0, 8'h00); nxt();
        chk("byte 22", 16'h08, rd);
        acc(ACC_DIRECT, 1'b0, 1'b1, 16'h007F, 1'b0, 8'h00); nxt();
        chk("bit 7F", 16'h1, 16'(rd[0]));
        idle();
        $display("test bits done");
    endtask : t_bits

    task automatic t_prog();
        fwe = 1'b1;
        acc(ACC_CODE, 1'b0, 1'b0, 16'h1234, 1'b0, 8'h00);
        chk("flash_re", 16'h1, fre);
        chk("flash_addr", 16'h1234, fad);
        nxt();
        chk("target", TGT_FLASH, tgt);
        chk("rdata", 16'h12 ^ 16'h34 ^ 16'h5A, rd);
        acc(ACC_CODE, 1'b0, 1'b0, 16'hFBFF, 1'b0, 8'h00);
        chk("lock", 16'h1, lock);
        chk("reserved", 16'h0, resv);
        nxt();
        acc(ACC_CODE, 1'b0, 1'b0, 16'hFE00, 1'b0, 8'h00);
        chk("reserved", 16'h1, resv);
        nxt();
        acc(ACC_CODE, 1'b0, 1'b0, 16'hFFFF, 1'b0, 8'h00);
        chk("out_of_range", 16'h0, oor);
        nxt();
        acc(ACC_CODE, 1'b0, 1'b0, 16'h7FFF, 1'b0, 8'h00);
        chk("lock", 16'h0, lock);
        nxt();
        acc(ACC_EXT, 1'b1, 1'b0, 16'h0ABC, 1'b0, 8'h3C);
        chk("flash_we", 16'h1, fwr);
        nxt();
        chk("target", TGT_FLASH_WR, tgt);
        fwe = 1'b0;
        acc(ACC_EXT, 1'b1, 1'b0, 16'h0FFF, 1'b0, 8'hC3);
        chk("flash_we", 16'h0, fwr);
        nxt();
        acc(ACC_EXT, 1'b0, 1'b0, 16'h0FFF, 1'b0, 8'h00);
        chk("flash_re", 16'h0, fre);
        nxt();
        chk("target", TGT_AUXILIARY_ONCHIP_RAM, tgt);
        chk("rdata", 16'hC3, rd);
        idle();
        $display("test program done");
    endtask : t_prog

    initial
    begin
        repeat (4) @(posedge clk_i);
        @(negedge clk_i);
        resetn_i = 1'b1;
        t_stack();
        t_banks();
        t_bits();
        t_prog();
        print_verdict();
    end

    initial
    begin
        repeat (5000) @(posedge clk_i);
        n_mismatch++;
        print_verdict();
    end
endmodule : memory_space_decoder_tb

`default_nettype wire
